// file: inc/ssc_pkg.sv
package ssc_pkg;

  // register location and layout
  localparam logic [7:0]  SSC_SYSCTL_OFFSET   = 8'h80;
  localparam int          SSC_RSV_DRIVE_BIT   = 22;
  localparam int          SSC_PROT_DIS_BIT    = 21;
  localparam int          SSC_REDZV_BIT       = 20;
  localparam int          SSC_CARD_DMA_REQUEST_LINE_EN_BIT     = 19;
  localparam int          SSC_CHAN_LSB        = 16;
  localparam int          SSC_CHAN_MSB        = 18;
  localparam int          SSC_BURST_DN_BIT    = 15;
  localparam int          SSC_BURST_UP_BIT    = 14;
  localparam int          SSC_ACTIVITY_BIT    = 13;
  localparam int          SSC_CLAMP_BIT       = 12;
  localparam int          SSC_STREAM_BIT      = 11;
  localparam int          SSC_UP_DLY_BIT      = 10;
  localparam int          SSC_DN_DLY_BIT      = 9;
  localparam int          SSC_PROBE_BIT       = 8;
  localparam int          SSC_RSVD7_BIT       = 7;

  // field reset values, bus-master channel code and writable mask
  localparam logic [2:0]  SSC_CHAN_RESET      = 3'h4;
  localparam logic [2:0]  SSC_CHAN_BUS_MASTER = 3'h4;
  localparam logic [31:0] SSC_RW_MASK         = 32'h007F_C000;
  localparam logic [31:0] SSC_FIELDS_RESET    = 32'h0004_9000;

endpackage

// file: src/ssc_sysctl.sv
`timescale 1ns/1ps
`default_nettype none
// Contract
// - bit 22 set drives reserved card terminals low for inserted 32-bit cards
// - bit 21 zero keeps 16-bit supply protection on; one disables it
// - bit 20 set floats address terminals A25-A22 for 16-bit cards
// - bit 19 set passes card DMA requests unless the channel is 4; zero ignores request line
// - bits 18-16 pick DMA channel; 4 means bus master, unused
// - bit 15 set, reset one, allows downstream read bursts
// - bit 14 set, reset zero, allows upstream read bursts
// - bit 13 set on card access, cleared by software read with byte 1 enabled
// - bit 12 always reads one
// - bit 11 high from power change request until stream completes
// - bit 10 set after power-up stream until up delay expires
// - bit 9 set after power-down stream until down delay expires
// - bit 8 high while card interrogation runs
// - bit 7 always reads zero
// - register sits at configuration offset 80h, reset combines field defaults
module ssc_sysctl
  import ssc_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        rst_n,
  input  wire logic        cfg_sel,
  input  wire logic [7:0]  cfg_addr,
  input  wire logic        cfg_wr,
  input  wire logic        cfg_rd,
  input  wire logic [3:0]  cfg_be,
  input  wire logic [31:0] cfg_wdata,
  output logic      [31:0] cfg_rdata,
  input  wire logic        card_is_32bit,
  input  wire logic        card_inserted,
  input  wire logic        card_access,
  input  wire logic        power_change_req,
  input  wire logic        power_stream_done,
  input  wire logic        power_stream_up,
  input  wire logic        power_delay_done,
  input  wire logic        probe_start,
  input  wire logic        probe_done,
  input  wire logic        card_dma_request_line,
  output logic             reserved_terminal_oe,
  output logic             reserved_terminal_out,
  output logic             supply_protect_en,
  output logic             addr_hi_oe_n,
  output logic             dma_request,
  output logic      [2:0]  dma_channel,
  output logic             dma_chan_16bit,
  output logic             read_burst_down_en,
  output logic             read_burst_up_en
);

  // pin inputs pass two flops before use
  logic [8:0] sync1_q;
  logic [8:0] sync2_q;
  logic [8:0] pins;
  assign pins = {card_is_32bit, card_inserted, card_access, power_change_req, power_stream_done,
                 power_stream_up, power_delay_done, probe_start, probe_done};

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      sync1_q <= 9'h000;
      sync2_q <= 9'h000;
    end
    else
    begin
      sync1_q <= pins;
      sync2_q <= sync1_q;
    end
  end

  // synchronised copies, one per pin, in the order packed above
  logic       s_32;
  logic       s_ins;
  logic       s_acc;
  logic       s_chg;
  logic       s_sdone;
  logic       s_up;
  logic       s_ddone;
  logic       s_pstart;
  logic       s_pdone;
  assign {s_32, s_ins, s_acc, s_chg, s_sdone, s_up, s_ddone, s_pstart, s_pdone} = sync2_q;

  // card request line gets its own two-stage synchroniser
  logic card_dma_request_line_s1_q;
  logic card_dma_request_line_s2_q;

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      card_dma_request_line_s1_q <= 1'b0;
      card_dma_request_line_s2_q <= 1'b0;
    end
    else
    begin
      card_dma_request_line_s1_q <= card_dma_request_line;
      card_dma_request_line_s2_q <= card_dma_request_line_s1_q;
    end
  end

  // register access decode
  logic hit;
  logic wr_hit;
  logic rd_hit;
  assign hit    = cfg_sel && (cfg_addr == SSC_SYSCTL_OFFSET);
  assign wr_hit = hit && cfg_wr;
  assign rd_hit = hit && cfg_rd;

  // writable control fields, bits 22..14
  logic [31:0] ctl_q;
  logic [31:0] ctl_d;
  logic [31:0] be_mask;
  assign be_mask = {{8{cfg_be[3]}}, {8{cfg_be[2]}}, {8{cfg_be[1]}}, {8{cfg_be[0]}}};

  always_comb
  begin
    // byte enables gate each byte; read-only and reserved bits never take write data
    ctl_d = ctl_q;
    if (wr_hit)
    begin
      ctl_d = (ctl_q & ~(SSC_RW_MASK & be_mask)) | (cfg_wdata & SSC_RW_MASK & be_mask);
    end
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      ctl_q <= SSC_FIELDS_RESET & SSC_RW_MASK;
    end
    else
    begin
      ctl_q <= ctl_d;
    end
  end

  // status flags
  logic act_q;
  logic act_d;
  logic stream_q;
  logic stream_d;
  logic up_q;
  logic up_d;
  logic dn_q;
  logic dn_d;
  logic probe_q;
  logic probe_d;
  logic sdone_prev_q;
  logic sdone_rise;
  logic act_rd_clr;
  // the stream counts as finished on the rising edge of its done level only
  assign sdone_rise = s_sdone && !sdone_prev_q;
  // a read clears activity only when the byte holding the flag is enabled
  assign act_rd_clr = rd_hit && cfg_be[1];

  always_comb
  begin
    // activity: a card access in the same cycle as the read clear wins
    act_d = act_q;
    if (act_rd_clr)
    begin
      act_d = 1'b0;
    end
    if (s_acc)
    begin
      act_d = 1'b1;                // set beats clear
    end

    // stream busy: a new request wins over the done edge
    stream_d = stream_q;
    if (sdone_rise)
    begin
      stream_d = 1'b0;
    end
    if (s_chg)
    begin
      stream_d = 1'b1;
    end

    // settling flags: the done edge picks the direction, expiry clears both
    up_d = up_q;
    dn_d = dn_q;
    if (s_ddone)
    begin
      up_d = 1'b0;
      dn_d = 1'b0;
    end
    if (sdone_rise && stream_q)
    begin
      up_d = s_up;
      dn_d = !s_up;
    end

    // probe busy: a start wins over a same-cycle finish
    probe_d = probe_q;
    if (s_pdone)
    begin
      probe_d = 1'b0;
    end
    if (s_pstart)
    begin
      probe_d = 1'b1;
    end
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      act_q        <= 1'b0;
      stream_q     <= 1'b0;
      up_q         <= 1'b0;
      dn_q         <= 1'b0;
      probe_q      <= 1'b0;
      sdone_prev_q <= 1'b0;
    end
    else
    begin
      act_q        <= act_d;
      stream_q     <= stream_d;
      up_q         <= up_d;
      dn_q         <= dn_d;
      probe_q      <= probe_d;
      sdone_prev_q <= s_sdone;
    end
  end

  // read data assembly
  logic [31:0] rd_word;

  always_comb
  begin
    rd_word                   = ctl_q;
    rd_word[SSC_ACTIVITY_BIT] = act_q;
    rd_word[SSC_CLAMP_BIT]    = 1'b1;
    rd_word[SSC_STREAM_BIT]   = stream_q;
    rd_word[SSC_UP_DLY_BIT]   = up_q;
    rd_word[SSC_DN_DLY_BIT]   = dn_q;
    rd_word[SSC_PROBE_BIT]    = probe_q;
    rd_word[SSC_RSVD7_BIT]    = 1'b0;
  end

  // registered outputs
  logic [31:0] rdata_d;
  logic        rsv_oe_d;
  logic [2:0]  chan;
  logic        prot_en_d;
  logic        addr_float_d;
  logic        dma_req_d;
  logic        chan_16_d;
  logic        burst_dn_d;
  logic        burst_up_d;
  assign chan = ctl_q[SSC_CHAN_MSB:SSC_CHAN_LSB];

  // next values for the pin-side outputs; every one of them leaves through a flop
  always_comb
  begin
    rdata_d = 32'h0000_0000;
    if (rd_hit)
    begin
      rdata_d = rd_word;                                      // stands one cycle, then idles at zero
    end
    rsv_oe_d     = ctl_q[SSC_RSV_DRIVE_BIT] && s_ins && s_32;
    prot_en_d    = !ctl_q[SSC_PROT_DIS_BIT];
    addr_float_d = ctl_q[SSC_REDZV_BIT] && !s_32;
    dma_req_d    = ctl_q[SSC_CARD_DMA_REQUEST_LINE_EN_BIT] && card_dma_request_line_s2_q && (chan != SSC_CHAN_BUS_MASTER);
    chan_16_d    = chan[2] && (chan != SSC_CHAN_BUS_MASTER);
    burst_dn_d   = ctl_q[SSC_BURST_DN_BIT];
    burst_up_d   = ctl_q[SSC_BURST_UP_BIT];
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      cfg_rdata             <= 32'h0000_0000;
      reserved_terminal_oe  <= 1'b0;
      reserved_terminal_out <= 1'b0;
      supply_protect_en     <= 1'b1;
      addr_hi_oe_n          <= 1'b0;
      dma_request           <= 1'b0;
      dma_channel           <= SSC_CHAN_RESET;
      dma_chan_16bit        <= 1'b0;
      read_burst_down_en    <= 1'b1;
      read_burst_up_en      <= 1'b0;
    end
    else
    begin
      cfg_rdata             <= rdata_d;
      reserved_terminal_oe  <= rsv_oe_d;
      reserved_terminal_out <= 1'b0;
      supply_protect_en     <= prot_en_d;
      addr_hi_oe_n          <= addr_float_d;
      dma_request           <= dma_req_d;
      dma_channel           <= chan;
      dma_chan_16bit        <= chan_16_d;
      read_burst_down_en    <= burst_dn_d;
      read_burst_up_en      <= burst_up_d;
    end
  end

endmodule
`default_nettype wire

// file: tb/ssc_sysctl_chk.sv
`timescale 1ns/1ps
`default_nettype none
module ssc_sysctl_chk
  import ssc_pkg::*;
(
  input wire logic        clk,
  input wire logic        rst_n,
  input wire logic        cfg_sel,
  input wire logic [7:0]  cfg_addr,
  input wire logic        cfg_wr,
  input wire logic        cfg_rd,
  input wire logic [3:0]  cfg_be,
  input wire logic [31:0] cfg_wdata,
  input wire logic [31:0] cfg_rdata,
  input wire logic        reserved_terminal_out,
  input wire logic        supply_protect_en,
  input wire logic        dma_request,
  input wire logic [2:0]  dma_channel,
  input wire logic        dma_chan_16bit,
  input wire logic        read_burst_down_en,
  input wire logic        read_burst_up_en
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_n);
  // register hits on the configuration bus
  wire rh = cfg_sel && cfg_rd && cfg_addr == SSC_SYSCTL_OFFSET;
  wire wh = cfg_sel && cfg_wr && cfg_addr == SSC_SYSCTL_OFFSET && cfg_be == 4'hF;
  // full write, one cycle with no write, then a read of the same word
  sequence s_wr_rd;
    wh ##1 !cfg_wr ##1 rh;
  endsequence
  chk_rd_idle: assert property (!$past(rh) |-> cfg_rdata == 32'h0) else $error("rdata not idle");
  chk_fixed_bits: assert property ($past(rh) |-> cfg_rdata[12] && !cfg_rdata[7])
    else $error("fixed bits wrong");
  chk_outer_zero: assert property ($past(rh) |-> cfg_rdata[31:23] == 9'h0)
    else $error("outer bits set");
  chk_rd_back: assert property (s_wr_rd |=> cfg_rdata[22:14] == $past(cfg_wdata[22:14], 3))
    else $error("readback wrong");
  chk_prot_follow: assert property (wh |-> ##2 supply_protect_en == !$past(cfg_wdata[21], 2))
    else $error("protect wrong");
  chk_burst_follow: assert property (wh |-> ##2 {read_burst_down_en, read_burst_up_en} == $past(cfg_wdata[15:14], 2))
    else $error("burst wrong");
  chk_chan_follow: assert property (wh |-> ##2 dma_channel == $past(cfg_wdata[18:16], 2))
    else $error("channel wrong");
  chk_chan_width: assert property (dma_chan_16bit == (dma_channel > 3'h4))
    else $error("width wrong");
  chk_dma_gate: assert property (dma_request |-> dma_channel != 3'h4) else $error("dma on ch4");
  chk_term_low: assert property (!reserved_terminal_out) else $error("terminal high");
endmodule
bind ssc_sysctl ssc_sysctl_chk chk_i (.clk, .rst_n, .cfg_sel, .cfg_addr, .cfg_wr, .cfg_rd, .cfg_be, .cfg_wdata,
  .cfg_rdata, .reserved_terminal_out, .supply_protect_en, .dma_request, .dma_channel, .dma_chan_16bit,
  .read_burst_down_en, .read_burst_up_en);
`default_nettype wire

// file: tb/ssc_far_side.sv
`timescale 1ns/1ps
`default_nettype none
module ssc_far_side (
  input  wire logic clk,
  input  wire logic req,
  output logic      done,
  output logic      dly
);
  int n = 0;
  // power switch cycle counted from each request
  always @(posedge clk)
    n <= req ? 1 : (n != 0 && n < 20) ? n + 1 : 0;
  // stream ends, then settling ends; both fall when the cycle is over
  assign done = n >= 6 && n < 20;
  assign dly  = n >= 13 && n < 20;
endmodule
`default_nettype wire

// file: tb/socket_system_control_fields_bench.sv
`timescale 1ns/1ps
`default_nettype none
module socket_system_control_fields_bench;
  import ssc_pkg::*;
  logic clk = 0, rst_n = 0, cfg_sel = 0, cfg_wr = 0, cfg_rd = 0, card_is_32bit = 0, card_inserted = 0;
  logic card_dma_request_line = 0, power_stream_up = 0, power_stream_done, power_delay_done;
  logic [7:0] cfg_addr = 0;
  logic [3:0] cfg_be = 4'hF, ev = 0;
  logic [31:0] cfg_wdata = 0, cfg_rdata, d, rw = 32'h0004_8000;
  logic oe, oq, prot, zv, dmq, c16, bdn, bup;
  logic [2:0] ch;
  int bad_count = 0, n_checks = 0;
  ssc_sysctl uut (.clk, .rst_n, .cfg_sel, .cfg_addr, .cfg_wr, .cfg_rd, .cfg_be, .cfg_wdata, .cfg_rdata,
    .card_is_32bit, .card_inserted, .card_access(ev[0]), .power_change_req(ev[1]), .power_stream_done,
    .power_stream_up, .power_delay_done, .probe_start(ev[2]), .probe_done(ev[3]), .card_dma_request_line,
    .reserved_terminal_oe(oe), .reserved_terminal_out(oq), .supply_protect_en(prot), .addr_hi_oe_n(zv),
    .dma_request(dmq), .dma_channel(ch), .dma_chan_16bit(c16), .read_burst_down_en(bdn),
    .read_burst_up_en(bup));
  ssc_far_side far (.clk, .req(ev[1]), .done(power_stream_done), .dly(power_delay_done));
  always #20 clk = ~clk;
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp)
    begin
      bad_count++;
      $display("Error %0t got %h want %h", $time, got, exp);
    end
  endtask
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] v);
    @(posedge clk);
    cfg_sel <= 1;
    cfg_addr <= a;
    cfg_wr <= w;
    cfg_rd <= !w;
    cfg_wdata <= v;
    @(posedge clk);
    cfg_sel <= 0;
    cfg_wr <= 0;
    cfg_rd <= 0;
  endtask
  // read and compare with the model word plus expected status bits
  task automatic rdc(input logic [7:0] a, input logic [31:0] st);
    bus(0, a, 0);
    // the word launched at the strobe edge still stands at the next edge
    @(posedge clk);
    chk(cfg_rdata, a == 8'h80 ? rw | 32'h0000_1000 | st : 0);
  endtask
  task automatic pulse(input int k);
    @(posedge clk);
    ev[k] <= 1;
    @(posedge clk);
    ev[k] <= 0;
    repeat (3) @(posedge clk);
  endtask
  task automatic conclude();
    $display("checks %0d mismatches %0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  // watchdog
  initial
  begin
    #100000;
    bad_count++;
    conclude();
  end
  initial
  begin
    void'($urandom(32'h81c3));
    repeat (20) @(posedge clk);
    rst_n <= 1;
    card_inserted <= 1;
    rdc(8'h80, 0);
    chk({oe, oq, prot, zv, dmq, ch, c16, bdn, bup}, {4'b0010, 1'b0, SSC_CHAN_RESET, 3'b010});
    $display("reset test done");
    for (int i = 0; i < 8; i++)
    begin
      d = $urandom;
      d[18:16] = i[2:0];
      // two passes force a requesting 16-bit card and a driven 32-bit card
      if (i[2:1] == 2'b01)
      begin
        d[22:19] = 4'hF;
        d[1:0]   = {!i[0], i[0]};
      end
      card_is_32bit <= d[0];
      card_dma_request_line <= d[1] & !d[0];
      bus(1, 8'h80, d);
      rw = d & SSC_RW_MASK;
      rdc(8'h80, 0);
      chk({oe, oq, prot, zv, dmq, ch, c16, bdn, bup}, {d[22] & d[0], 1'b0, !d[21], d[20] & !d[0],
        d[19] & d[1] & !d[0] & (i != 4), d[18:16], i > 4, d[15], d[14]});
    end
    cfg_be <= 4'h4;
    bus(1, 8'h80, 32'hFFFF_FFFF);
    cfg_be <= 4'hF;
    rw = rw | (32'h00FF_0000 & SSC_RW_MASK);
    rdc(8'h80, 0);
    $display("field test done");
    bus(1, 8'h84, 32'hFFFF_FFFF);
    rdc(8'h84, 0);
    rdc(8'h80, 0);
    pulse(0);
    cfg_be <= 4'hD;
    rdc(8'h80, 32'h0000_2000);
    cfg_be <= 4'hF;
    rdc(8'h80, 32'h0000_2000);
    rdc(8'h80, 0);
    pulse(2);
    rdc(8'h80, 32'h0000_0100);
    pulse(3);
    rdc(8'h80, 0);
    $display("status test done");
    for (int up = 1; up >= 0; up--)
    begin
      power_stream_up <= up[0];
      pulse(1);
      rdc(8'h80, 32'h0000_0800);
      repeat (5) @(posedge clk);
      rdc(8'h80, up ? 32'h0000_0400 : 32'h0000_0200);
      repeat (10) @(posedge clk);
      rdc(8'h80, 0);
    end
    $display("power test done");
    conclude();
  end
endmodule
`default_nettype wire
